// file: uic_pkg.sv
// Shared constants, state encodings and carrier types of the user interface block
package uic_pkg;

  // ****************************************************************
  // Play-mode codes
  // ****************************************************************
  localparam logic [2:0] PLAY_CODE = 3'h0;
  localparam logic [2:0] REWIND_CODE = 3'h1;
  localparam logic [2:0] STOP_CODE = 3'h2;
  localparam logic [2:0] FFWD_CODE = 3'h3;
  localparam logic [2:0] NOOP_CODE = 3'h4;

  // ****************************************************************
  // Volume defaults
  // ****************************************************************
  localparam int VOL_W = 6;
  localparam logic [5:0] VOL_MIN_DEF = 6'h00;
  localparam logic [5:0] VOL_MAX_DEF = 6'h3f;
  localparam logic [5:0] VOL_INIT_DEF = 6'h20;
  localparam logic [5:0] VOL_ONE = 6'h01;

  // ****************************************************************
  // Power sequencer timing
  // ****************************************************************
  localparam int RESET_WAIT_CYCLES = 2;

  // ****************************************************************
  // Wishbone register map
  // ****************************************************************
  localparam int WB_ADR_W = 4;
  localparam logic [3:0] STATUS_OFS = 4'h0;
  localparam logic [3:0] DISPLAY_OFS = 4'h4;
  localparam int TRACK_LSB = 0;
  localparam int TRACK_W = 7;
  localparam logic [6:0] TRACK_RST = 7'h00;
  localparam logic [6:0] TRACK_TEN = 7'h0a;
  localparam int STATUS_W = 14;

  // ****************************************************************
  // Reset values of the user state
  // ****************************************************************
  localparam logic POWER_ON_RST = 1'b1;
  localparam logic MUTE_RST = 1'b0;
  localparam logic RESUME_RST = 1'b0;

  // ****************************************************************
  // State encodings, Gray along the usual path
  // ****************************************************************
  typedef enum logic [1:0] {
    VOL_IDLE = 2'h0,
    VOL_CHECK = 2'h1,
    VOL_STEP = 2'h3,
    VOL_AWAIT = 2'h2
  } uic_vol_state_t;

  typedef enum logic [2:0] {
    PWR_WAIT_SUPPLY = 3'h0,
    PWR_WAIT1 = 3'h1,
    PWR_WAIT2 = 3'h3,
    PWR_RUN = 3'h2,
    PWR_SHUT = 3'h6,
    PWR_OFF = 3'h7
  } uic_pwr_state_t;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic power_on;
    logic mute;
    logic fast_forward;
    logic rewind;
    logic stop;
    logic play;
    logic volume_down;
    logic volume_up;
  } uic_buttons_t;

  localparam int NUM_BUTTONS = 8;

  typedef struct packed {
    logic sys_reset;
    logic update_request;
    logic power_on;
    logic mute;
    logic [5:0] volume;
    logic resume_playing;
    logic [2:0] play_mode;
  } uic_status_t;

endpackage

// file: uic_edge_det.sv
// Button synchroniser and rising-edge detector giving one pulse per press
`timescale 1ns/1ps
module uic_edge_det (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic level_i,
  output logic pulse_o
);

  logic sync1_ff;
  logic sync2_ff;
  logic hist_ff;
  logic pulse_ff;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= level_i; // R19
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hist_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end else begin
      hist_ff <= sync2_ff;
      pulse_ff <= sync2_ff & ~hist_ff; // R19
    end
  end

  assign pulse_o = pulse_ff;

endmodule // uic_edge_det

// file: uic_user_interface.sv
// User interface, sound, icon, seven-segment and power sequencing logic
// Function
// [R1] Report play mode as a 3-bit code
// [R2] Return to remembered mode after seeking
// [R3] Ignore play presses while playing
// [R4] Ignore stop presses while idle
// [R5] Volume buttons step a 6-bit counter
// [R6] Volume counter saturates at both limits
// [R7] Request enters limit check from idle
// [R8] At a limit return idle, no request
// [R9] Step, then hold request until done
// [R10] Mute toggles per press, changed pulse out
// [R11] Controller mutes with zero, restores volume
// [R12] Power toggle flips per press, preset on
// [R13] Power off becomes a shutdown request
// [R14] Decode mode icons, register status icons
// [R15] Error over download, both block others
// [R16] Track number drives seven-segment digits
// [R17] Hold reset until supply, two waits
// [R18] Shutdown: reset first, then drop enable
// [R19] Buttons synchronised, one pulse per press
// [R20] Volume limits and start are parameters
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module uic_user_interface #(
  parameter logic [5:0] VOL_MIN = uic_pkg::VOL_MIN_DEF,
  parameter logic [5:0] VOL_MAX = uic_pkg::VOL_MAX_DEF,
  parameter logic [5:0] VOL_INIT = uic_pkg::VOL_INIT_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire uic_pkg::uic_buttons_t buttons_i,
  input wire logic seek_done_i,
  input wire logic decoder_update_done_i,
  input wire logic supply_good_i,
  input wire logic display_err_i,
  input wire logic download_active_i,
  input wire logic [1:0] battery_level_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [2:0] play_mode_o,
  output logic [5:0] volume_level_o,
  output logic volume_update_request_o,
  output logic mute_state_o,
  output logic mute_changed_o,
  output logic power_on_o,
  output logic sys_reset_o,
  output logic converter_enable_o,
  output logic [7:0] mode_icon_o,
  output logic mute_icon_o,
  output logic error_icon_o,
  output logic download_icon_o,
  output logic [2:0] volume_icon_o,
  output logic [1:0] battery_icon_o,
  output logic [6:0] seg_tens_o,
  output logic [6:0] seg_ones_o
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  initial begin
    if (VOL_MIN >= VOL_MAX || VOL_INIT < VOL_MIN || VOL_INIT > VOL_MAX) begin // R20
      $error("volume limits or start value out of order");
    end
  end

  // ****************************************************************
  // Button edge detection
  // ****************************************************************
  logic [uic_pkg::NUM_BUTTONS-1:0] press;
  uic_pkg::uic_buttons_t ev;

  genvar gi;
  generate
    for (gi = 0; gi < uic_pkg::NUM_BUTTONS; gi++) begin : g_btn
      uic_edge_det u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(buttons_i[gi]),
        .pulse_o(press[gi])
      ); // R19
    end
  endgenerate

  assign ev = uic_pkg::uic_buttons_t'(press);

  // ****************************************************************
  // Play mode logic
  // ****************************************************************
  logic [2:0] play_ff;
  logic resume_ff;
  logic seeking;

  assign seeking = (play_ff == uic_pkg::REWIND_CODE) || (play_ff == uic_pkg::FFWD_CODE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      play_ff <= uic_pkg::STOP_CODE; // R1
      resume_ff <= uic_pkg::RESUME_RST;
    end else if (ev.play) begin
      if (play_ff != uic_pkg::PLAY_CODE) begin // R3
        play_ff <= uic_pkg::PLAY_CODE;
        resume_ff <= 1'b1;
      end
    end else if (ev.stop) begin
      if (resume_ff || seeking) begin // R4
        play_ff <= uic_pkg::STOP_CODE;
        resume_ff <= 1'b0;
      end
    end else if (ev.rewind) begin
      play_ff <= uic_pkg::REWIND_CODE; // R1
    end else if (ev.fast_forward) begin
      play_ff <= uic_pkg::FFWD_CODE; // R1
    end else if (seeking && seek_done_i) begin
      play_ff <= resume_ff ? uic_pkg::PLAY_CODE : uic_pkg::STOP_CODE; // R2
    end
  end

  // ****************************************************************
  // Volume control state machine
  // ****************************************************************
  uic_pkg::uic_vol_state_t vol_state_ff;
  logic [5:0] vol_ff;
  logic dir_up_ff;
  logic upd_req_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vol_state_ff <= uic_pkg::VOL_IDLE;
      dir_up_ff <= 1'b0;
    end else begin
      case (vol_state_ff)
        uic_pkg::VOL_IDLE: begin
          if (ev.volume_up || ev.volume_down) begin // R7
            vol_state_ff <= uic_pkg::VOL_CHECK;
            dir_up_ff <= ev.volume_up;
          end
        end
        uic_pkg::VOL_CHECK: begin
          if ((dir_up_ff && vol_ff >= VOL_MAX) || (!dir_up_ff && vol_ff <= VOL_MIN)) begin
            vol_state_ff <= uic_pkg::VOL_IDLE; // R8
          end else begin
            vol_state_ff <= uic_pkg::VOL_STEP; // R7
          end
        end
        uic_pkg::VOL_STEP: begin
          vol_state_ff <= uic_pkg::VOL_AWAIT; // R9
        end
        uic_pkg::VOL_AWAIT: begin
          if (decoder_update_done_i) begin // R9
            vol_state_ff <= uic_pkg::VOL_IDLE;
          end
        end
        default: begin
          vol_state_ff <= uic_pkg::VOL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vol_ff <= VOL_INIT; // R20
    end else if (vol_state_ff == uic_pkg::VOL_STEP) begin
      vol_ff <= dir_up_ff ? vol_ff + uic_pkg::VOL_ONE : vol_ff - uic_pkg::VOL_ONE; // R5 R6
    end
  end

  // Request rises on entering the await state and falls with done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_req_ff <= 1'b0;
    end else if (vol_state_ff == uic_pkg::VOL_STEP) begin
      upd_req_ff <= 1'b1; // R9
    end else if (vol_state_ff == uic_pkg::VOL_AWAIT && decoder_update_done_i) begin
      upd_req_ff <= 1'b0; // R9
    end
  end

  // ****************************************************************
  // Mute and on/off toggles
  // ****************************************************************
  logic mute_ff;
  logic mute_changed_ff;
  logic on_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mute_ff <= uic_pkg::MUTE_RST;
      mute_changed_ff <= 1'b0;
    end else begin
      mute_ff <= mute_ff ^ ev.mute; // R10
      mute_changed_ff <= ev.mute; // R10
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_ff <= uic_pkg::POWER_ON_RST; // R12
    end else if (ev.power_on) begin
      on_ff <= ~on_ff; // R12 R13
    end
  end

  // ****************************************************************
  // Power sequencer
  // ****************************************************************
  uic_pkg::uic_pwr_state_t pwr_ff;
  uic_pkg::uic_pwr_state_t nxt_pwr;
  logic sys_reset_ff;
  logic conv_en_ff;
  logic power_fail;

  assign power_fail = !supply_good_i || !on_ff; // R13 R18

  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      uic_pkg::PWR_WAIT_SUPPLY: begin
        if (!on_ff) begin
          nxt_pwr = uic_pkg::PWR_SHUT;
        end else if (supply_good_i) begin
          nxt_pwr = uic_pkg::PWR_WAIT1; // R17
        end
      end
      uic_pkg::PWR_WAIT1: begin
        nxt_pwr = power_fail ? uic_pkg::PWR_SHUT : uic_pkg::PWR_WAIT2; // R17
      end
      uic_pkg::PWR_WAIT2: begin
        nxt_pwr = power_fail ? uic_pkg::PWR_SHUT : uic_pkg::PWR_RUN; // R17
      end
      uic_pkg::PWR_RUN: begin
        if (power_fail) begin
          nxt_pwr = uic_pkg::PWR_SHUT; // R18
        end
      end
      uic_pkg::PWR_SHUT: begin
        nxt_pwr = uic_pkg::PWR_OFF; // R18
      end
      uic_pkg::PWR_OFF: begin
        nxt_pwr = uic_pkg::PWR_OFF;
      end
      default: begin
        nxt_pwr = uic_pkg::PWR_WAIT_SUPPLY;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_ff <= uic_pkg::PWR_WAIT_SUPPLY;
      sys_reset_ff <= 1'b1; // R17
      conv_en_ff <= 1'b1;
    end else begin
      pwr_ff <= nxt_pwr;
      sys_reset_ff <= (nxt_pwr != uic_pkg::PWR_RUN); // R17 R18
      conv_en_ff <= (nxt_pwr != uic_pkg::PWR_OFF); // R18
    end
  end

  // ****************************************************************
  // Wishbone registers
  // ****************************************************************
  logic [6:0] track_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic wb_req;
  uic_pkg::uic_status_t status;

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign status = '{sys_reset: sys_reset_ff, update_request: upd_req_ff, power_on: on_ff,
                    mute: mute_ff, volume: vol_ff, resume_playing: resume_ff,
                    play_mode: play_ff};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          uic_pkg::STATUS_OFS: rdat_ff <= {{(32-uic_pkg::STATUS_W){1'b0}}, status};
          uic_pkg::DISPLAY_OFS: rdat_ff <= {25'h0, track_ff};
          default: rdat_ff <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      track_ff <= uic_pkg::TRACK_RST;
    end else if (wb_req && wb_we_i && wb_adr_i == uic_pkg::DISPLAY_OFS && wb_sel_i[0]) begin
      track_ff <= wb_dat_i[uic_pkg::TRACK_LSB +: uic_pkg::TRACK_W];
    end
  end

  // ****************************************************************
  // Icon and seven-segment logic
  // ****************************************************************
  function automatic logic [6:0] seg_of(input logic [6:0] d);
    case (d)
      7'h00: seg_of = 7'h3f;
      7'h01: seg_of = 7'h06;
      7'h02: seg_of = 7'h5b;
      7'h03: seg_of = 7'h4f;
      7'h04: seg_of = 7'h66;
      7'h05: seg_of = 7'h6d;
      7'h06: seg_of = 7'h7d;
      7'h07: seg_of = 7'h07;
      7'h08: seg_of = 7'h7f;
      7'h09: seg_of = 7'h6f;
      default: seg_of = 7'h00;
    endcase
  endfunction

  logic [7:0] mode_icon_ff;
  logic mute_icon_ff;
  logic err_icon_ff;
  logic dnld_icon_ff;
  logic [2:0] vol_icon_ff;
  logic [1:0] bat_icon_ff;
  logic [6:0] seg_tens_ff;
  logic [6:0] seg_ones_ff;
  logic others_on;

  assign others_on = !display_err_i && !download_active_i; // R15

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_icon_ff <= 8'h00;
      mute_icon_ff <= 1'b0;
      err_icon_ff <= 1'b0;
      dnld_icon_ff <= 1'b0;
      vol_icon_ff <= 3'h0;
      bat_icon_ff <= 2'h0;
    end else begin
      mode_icon_ff <= others_on ? (8'h01 << play_ff) : 8'h00; // R14 R15
      err_icon_ff <= display_err_i; // R14 R15
      dnld_icon_ff <= download_active_i && !display_err_i; // R15
      mute_icon_ff <= others_on && mute_ff; // R14
      vol_icon_ff <= others_on ? vol_ff[5:3] : 3'h0; // R14
      bat_icon_ff <= others_on ? battery_level_i : 2'h0; // R14
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seg_tens_ff <= 7'h00;
      seg_ones_ff <= 7'h00;
    end else begin
      seg_tens_ff <= seg_of(track_ff / uic_pkg::TRACK_TEN); // R16
      seg_ones_ff <= seg_of(track_ff % uic_pkg::TRACK_TEN); // R16
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_ff;
  assign play_mode_o = play_ff;
  assign volume_level_o = vol_ff;
  assign volume_update_request_o = upd_req_ff;
  assign mute_state_o = mute_ff;
  assign mute_changed_o = mute_changed_ff;
  assign power_on_o = on_ff;
  assign sys_reset_o = sys_reset_ff;
  assign converter_enable_o = conv_en_ff;
  assign mode_icon_o = mode_icon_ff;
  assign mute_icon_o = mute_icon_ff;
  assign error_icon_o = err_icon_ff;
  assign download_icon_o = dnld_icon_ff;
  assign volume_icon_o = vol_icon_ff;
  assign battery_icon_o = bat_icon_ff;
  assign seg_tens_o = seg_tens_ff;
  assign seg_ones_o = seg_ones_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_play_ignored: assert property (ev.play && play_ff == uic_pkg::PLAY_CODE |=> play_ff == uic_pkg::PLAY_CODE) else $error("play press changed play mode"); // R3
  a_stop_ignored: assert property (ev.stop && !ev.play && !resume_ff && !seeking |=> play_ff == $past(play_ff)) else $error("stop press while idle acted"); // R4
  a_seek_resume: assert property (seeking && seek_done_i && press == 8'h00 |=> play_ff == ($past(resume_ff) ? uic_pkg::PLAY_CODE : uic_pkg::STOP_CODE)) else $error("no return to resume mode"); // R2
  a_vol_limit: assert property (vol_state_ff == uic_pkg::VOL_CHECK && dir_up_ff && vol_ff == VOL_MAX |=> vol_state_ff == uic_pkg::VOL_IDLE && !upd_req_ff && vol_ff == VOL_MAX) else $error("volume passed maximum"); // R6 R8
  a_vol_step: assert property (vol_state_ff == uic_pkg::VOL_CHECK && !dir_up_ff && vol_ff > VOL_MIN |=> ##1 vol_ff == $past(vol_ff, 2) - uic_pkg::VOL_ONE && upd_req_ff) else $error("volume step wrong"); // R5 R7 R9
  a_update_hold: assert property (upd_req_ff && !decoder_update_done_i |=> upd_req_ff) else $error("update request dropped early"); // R9
  a_mute_toggle: assert property (ev.mute |=> mute_changed_o && mute_ff != $past(mute_ff)) else $error("mute did not toggle"); // R10
  a_power_down: assert property (pwr_ff == uic_pkg::PWR_RUN && power_fail |=> sys_reset_o && converter_enable_o ##1 !converter_enable_o) else $error("shutdown order wrong"); // R18
  a_reset_release: assert property (pwr_ff == uic_pkg::PWR_WAIT_SUPPLY && supply_good_i && on_ff |=> sys_reset_o ##1 (sys_reset_o || power_fail)) else $error("reset released too early"); // R17
  a_icon_priority: assert property (display_err_i |=> error_icon_o && !download_icon_o && mode_icon_o == 8'h00) else $error("error icon priority broken"); // R15

  c_vol_update: cover property (vol_state_ff == uic_pkg::VOL_AWAIT && decoder_update_done_i);
  c_seek_done: cover property (seeking && seek_done_i && resume_ff);
  c_shutdown: cover property (pwr_ff == uic_pkg::PWR_SHUT);
  c_mute: cover property (mute_changed_o && mute_state_o);

endmodule // uic_user_interface

// file: uic_ctrl_model.sv
// Main control logic model: answers volume updates and seek completion
`timescale 1ns/1ps
module uic_ctrl_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic [2:0] play_mode_i,
  input wire logic update_request_i,
  input wire logic [5:0] volume_i,
  input wire logic mute_i,
  input wire logic mute_changed_i,
  output logic seek_done_o,
  output logic update_done_o,
  output logic [5:0] conv_vol_o
);
  // ****************************************************************
  // Response timing
  // ****************************************************************
  logic [3:0] wait_ff;
  logic seeking;
  assign seeking = play_mode_i == uic_pkg::REWIND_CODE || play_mode_i == uic_pkg::FFWD_CODE;
  always_ff @(posedge clk_i) begin
    if (rst_i || !(update_request_i || seeking)) begin
      wait_ff <= 4'h0;
    end else if (wait_ff != 4'hf) begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
  // Done stays up only while the request does, slow mode answers late
  assign update_done_o = update_request_i && wait_ff >= (slow_i ? 4'h9 : 4'h1);
  assign seek_done_o = !update_request_i && seeking && wait_ff >= 4'h5;
  // ****************************************************************
  // Converter volume register
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_vol_o <= 6'h00;
    end else if (mute_changed_i || update_done_o) begin
      conv_vol_o <= mute_i ? 6'h00 : volume_i;
    end
  end
endmodule // uic_ctrl_model

// file: uic_testbench.sv
// Self-checking testbench of the user interface block
`timescale 1ns/1ps
module testbench;
  logic clk_i, rst_i, supply, err_in, dnld, slow;
  logic [1:0] batt, batt_icon;
  uic_pkg::uic_buttons_t buttons;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [3:0] wb_adr;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic [2:0] play_mode, vol_icon;
  logic [5:0] volume, conv_vol, exp_vol;
  logic upd_req, mute, mute_changed, power_on, sys_reset, conv_en;
  logic mute_icon, err_icon, dn_icon, seek_done, upd_done;
  logic [7:0] mode_icon;
  logic [6:0] seg_tens, seg_ones;
  logic [15:0] lfsr;
  int bad_count, tests_run, cycles, chg_cnt, t;
  localparam logic [6:0] SEG_TAB [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
    7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  localparam int PM_BTN [6] = '{3, 2, 2, 4, 3, 5};
  localparam int PM_NOW [6] = '{2, 0, 0, 1, 2, 3};
  localparam int PM_END [6] = '{2, 0, 0, 0, 2, 2};

  uic_user_interface dut (.clk_i(clk_i), .rst_i(rst_i), .buttons_i(buttons),
    .seek_done_i(seek_done), .decoder_update_done_i(upd_done), .supply_good_i(supply),
    .display_err_i(err_in), .download_active_i(dnld), .battery_level_i(batt),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hf), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .play_mode_o(play_mode), .volume_level_o(volume), .volume_update_request_o(upd_req),
    .mute_state_o(mute), .mute_changed_o(mute_changed), .power_on_o(power_on),
    .sys_reset_o(sys_reset), .converter_enable_o(conv_en), .mode_icon_o(mode_icon),
    .mute_icon_o(mute_icon), .error_icon_o(err_icon), .download_icon_o(dn_icon),
    .volume_icon_o(vol_icon), .battery_icon_o(batt_icon), .seg_tens_o(seg_tens),
    .seg_ones_o(seg_ones));
  uic_ctrl_model partner (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .play_mode_i(play_mode), .update_request_i(upd_req), .volume_i(volume),
    .mute_i(mute), .mute_changed_i(mute_changed), .seek_done_o(seek_done),
    .update_done_o(upd_done), .conv_vol_o(conv_vol));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [5:0] step_vol(input logic [5:0] v, input logic u);
    if (u) begin
      return (v == uic_pkg::VOL_MAX_DEF) ? v : v + 6'h01;
    end
    return (v == uic_pkg::VOL_MIN_DEF) ? v : v - 6'h01;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic press(input int b);
    @(posedge clk_i);
    buttons[b] <= 1'b1;
    repeat (2) @(posedge clk_i);
    buttons[b] <= 1'b0;
    repeat (6) @(negedge clk_i);
  endtask
  task automatic vol(input logic u);
    logic [5:0] e;
    e = step_vol(exp_vol, u);
    press(u ? 0 : 1);
    chk(upd_req, e != exp_vol);
    exp_vol = e;
    // Only the bench timeout bounds a wait for done
    while (upd_req === 1'b1) begin
      @(negedge clk_i);
    end
    chk(volume, exp_vol);
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, timeout, pulse count
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    chg_cnt += (mute_changed === 1'b1);
    if (cycles == 60000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    rst_i = 1'b1;
    buttons = '0;
    {supply, err_in, dnld, slow, batt, wb_cyc, wb_stb, wb_we, wb_adr} = '0;
    wb_dat_w = '0;
    lfsr = 16'hd8c0;
    exp_vol = uic_pkg::VOL_INIT_DEF;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(negedge clk_i);
    chk({play_mode, volume, upd_req, mute, power_on, sys_reset, conv_en},
      {3'h2, 6'h20, 5'h07});
    @(posedge clk_i);
    supply <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk(sys_reset, 1);
    @(negedge clk_i);
    chk(sys_reset, 0);
    for (int i = 0; i < 6; i++) begin
      press(PM_BTN[i]);
      chk(play_mode, PM_NOW[i]);
      repeat (10) @(negedge clk_i);
      chk(play_mode, PM_END[i]);
      chk(mode_icon, 8'h01 << PM_END[i]);
    end
    chg_cnt = 0;
    press(6);
    chk({mute, mute_icon, conv_vol}, {2'h3, 6'h00});
    press(6);
    chk({chg_cnt[7:0], mute, conv_vol}, {8'd2, 1'b0, exp_vol});
    for (int i = 0; i < 30; i++) begin
      lfsr = nxt(lfsr);
      @(posedge clk_i);
      slow <= lfsr[5];
      vol(lfsr[0]);
    end
    repeat (64) vol(1'b1);
    repeat (66) vol(1'b0);
    wb(1'b0, uic_pkg::STATUS_OFS, 32'h0);
    chk(rd, {18'h0, 4'h2, exp_vol, 4'h2});
    wb(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      t = (i == 0) ? 99 : int'(lfsr % 16'd100);
      wb(1'b1, uic_pkg::DISPLAY_OFS, t);
      wb(1'b0, uic_pkg::DISPLAY_OFS, 32'h0);
      chk(rd, t);
      chk({seg_tens, seg_ones}, {SEG_TAB[t / 10], SEG_TAB[t % 10]});
    end
    @(posedge clk_i);
    err_in <= 1'b1;
    dnld <= 1'b1;
    batt <= lfsr[1:0];
    repeat (3) @(negedge clk_i);
    chk({err_icon, dn_icon, mode_icon}, 10'h200);
    @(posedge clk_i);
    err_in <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk({err_icon, dn_icon, mode_icon}, 10'h100);
    @(posedge clk_i);
    dnld <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk({mode_icon, vol_icon, batt_icon}, {8'h04, exp_vol[5:3], lfsr[1:0]});
    @(posedge clk_i);
    buttons.power_on <= 1'b1;
    repeat (5) @(negedge clk_i);
    chk({power_on, sys_reset, conv_en}, 3'b001);
    @(negedge clk_i);
    chk({power_on, sys_reset, conv_en}, 3'b011);
    @(negedge clk_i);
    chk({power_on, sys_reset, conv_en}, 3'b010);
    // Mid-run reset leaves the latched off state and restarts the sequencer
    @(posedge clk_i);
    buttons.power_on <= 1'b0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({power_on, sys_reset, conv_en, play_mode, volume}, {3'b111, 3'h2, 6'h20});
    repeat (2) @(negedge clk_i);
    chk(sys_reset, 1);
    @(negedge clk_i);
    chk(sys_reset, 0);
    tally_and_finish();
  end
endmodule // testbench
